// ==== core/clock_reset_power_manager.sv ====
`timescale 1ns/1ps
`default_nettype none
module clock_reset_power_manager
  import clock_reset_pkg::*;
#(
  parameter int WARMUP = WARMUP_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clock_enable,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe_n,
  input  wire logic        power_fail_reset,
  input  wire logic        power_on_reset,
  input  wire logic        watchdog_reset,
  input  wire logic        system_reset,
  input  wire logic        stop_mode,
  input  wire logic        stop_exit,
  input  wire logic        crystal_slow,
  input  wire wake_type    wake,
  input  wire control_type control,
  output logic             cpu_reset,
  output logic [15:0]      fetch_address,
  output logic             execute_hold,
  output logic [1:0]       clock_divide,
  output logic             auto_speed_restore_enable,
  output logic             osc_fail_detect_enable,
  output logic             osc_fail_flag,
  output logic             ring_clock_active,
  output logic             ring_start_select,
  output logic             timer_scale_slow,
  output logic             oscillator_run,
  output logic             watchdog_on_crystal
);
  typedef enum logic [3:0] {
    run_state    = 4'h1,
    reset_state  = 4'h2,
    warm_state   = 4'h4,
    ring_state   = 4'h8
  } state_type;

  state_type state;
  state_type next_state;

  // Two-stage synchronisers; stage one is read only by stage two
  logic        pin_meta, pin_sync;
  logic [5:0]  irq_meta, irq_sync;
  logic [1:0]  rx_meta, rx_sync, rx_last;
  logic        slow_meta, slow_sync;
  logic [1:0]  pin_high_count;
  logic [16:0] rst_wait;
  logic        in_stop_reset;
  logic        osc_fail_hold;
  logic        warm_start, warm_busy, warm_done;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_meta  <= 1'b0;
      pin_sync  <= 1'b0;
      irq_meta  <= 6'h00;
      irq_sync  <= 6'h00;
      rx_meta   <= 2'h3;
      rx_sync   <= 2'h3;
      rx_last   <= 2'h3;
      slow_meta <= 1'b0;
      slow_sync <= 1'b0;
    end else if (clock_enable) begin
      pin_meta  <= reset_pin_in;
      pin_sync  <= pin_meta;
      irq_meta  <= wake.irq_level;
      irq_sync  <= irq_meta;
      rx_meta   <= wake.rx_pin;
      rx_sync   <= rx_meta;
      rx_last   <= rx_sync;
      slow_meta <= crystal_slow;
      slow_sync <= slow_meta;
    end
  end

  // Pin must stay high three cycles before it counts
  wire pin_qualified = pin_sync && (pin_high_count == 2'(PIN_MIN_CYCLES - 1));
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_high_count <= 2'h0;
    end else if (clock_enable) begin
      if (!pin_sync) begin
        pin_high_count <= 2'h0;
      end else if (!pin_qualified) begin
        pin_high_count <= pin_high_count + 2'h1;
      end
    end
  end

  wire internal_reset = power_fail_reset || power_on_reset || watchdog_reset || system_reset;
  // Stopped oscillator is not a failure
  wire osc_failed = osc_fail_detect_enable && slow_sync && !stop_mode;
  wire any_reset  = pin_qualified || internal_reset || osc_fail_hold || osc_failed;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      osc_fail_hold <= 1'b0;
    end else if (clock_enable) begin
      osc_fail_hold <= osc_failed;
    end
  end

  // Active levels: low on a, b, d, f; high on c, e
  wire [5:0] irq_active   = irq_sync ^ 6'h2B;
  wire       irq_wake     = |(irq_active & wake.irq_enable & wake.irq_allowed);
  wire       rx_fall      = |(rx_last & ~rx_sync & wake.rx_enable);
  wire       tx_active    = |wake.tx_busy;
  wire       serial_busy  = |wake.tx_busy || |wake.rx_busy;
  wire       switch_back  = auto_speed_restore_enable && clock_divide == DIVIDE_SLOW &&
                            (irq_wake || rx_fall || tx_active);
  wire       slow_refused = control.divide == DIVIDE_SLOW && serial_busy;
  wire       write_ok     = control.write && !ring_clock_active && !slow_refused;
  wire [1:0] next_divide  = switch_back ? DIVIDE_ONE :
                            write_ok ? control.divide : clock_divide;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= reset_state;
    end else if (clock_enable) begin
      state <= next_state;
    end
  end

  always_comb begin
    next_state = state;
    warm_start = 1'b0;
    case (state)
      run_state: begin
        if (any_reset) begin
          next_state = reset_state;
        end else if (stop_exit) begin
          warm_start = 1'b1;
          next_state = ring_start_select ? ring_state : warm_state;
        end
      end
      reset_state: begin
        if (!any_reset && rst_wait == 17'h00000) begin
          next_state = run_state;
        end
      end
      warm_state: begin
        if (any_reset) begin
          next_state = reset_state;
        end else if (warm_done) begin
          next_state = run_state;
        end
      end
      ring_state: begin
        if (any_reset) begin
          next_state = reset_state;
        end else if (warm_done) begin
          next_state = run_state;
        end
      end
      default: next_state = reset_state;
    endcase
  end

  // Stop-mode reset requires a warmup before release
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rst_wait      <= 17'h00000;
      in_stop_reset <= 1'b0;
    end else if (clock_enable) begin
      if (any_reset && stop_mode) begin
        rst_wait      <= 17'(WARMUP - 1);
        in_stop_reset <= 1'b1;
      end else if (rst_wait != 17'h00000 && !any_reset) begin
        rst_wait <= rst_wait - 17'h00001;
      end else if (rst_wait == 17'h00000) begin
        in_stop_reset <= 1'b0;
      end
    end
  end

  warmup_counter #(
    .COUNT (WARMUP)
  ) crystal_warmup (
    .clock  (clock),
    .reset  (reset),
    .enable (clock_enable),
    .start  (warm_start),
    .busy   (warm_busy),
    .done   (warm_done)
  );

  wire in_reset = any_reset || state == reset_state;
  // Lock the divider from the edge that selects the ring clock, not one later
  wire next_ring = next_state == ring_state || osc_failed;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      clock_divide              <= DIVIDE_RESET;
      auto_speed_restore_enable <= 1'b0;
      osc_fail_detect_enable    <= 1'b0;
      osc_fail_flag             <= 1'b0;
      ring_start_select         <= 1'b0;
    end else if (clock_enable) begin
      if (in_reset || ring_clock_active || next_ring) begin
        clock_divide <= DIVIDE_RESET;
      end else begin
        clock_divide <= next_divide;
      end
      if (!in_reset && control.write) begin
        auto_speed_restore_enable <= control.restore_enable;
        ring_start_select         <= control.ring_select;
      end else if (in_reset) begin
        auto_speed_restore_enable <= 1'b0;
      end
      if (power_fail_reset) begin
        osc_fail_detect_enable <= 1'b0;
      end else if (control.detect_write) begin
        osc_fail_detect_enable <= control.detect_value;
      end
      // Set wins over a simultaneous software clear
      if (osc_failed) begin
        osc_fail_flag <= 1'b1;
      end else if (power_on_reset || control.flag_clear) begin
        osc_fail_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cpu_reset           <= 1'b1;
      reset_pin_out       <= 1'b0;
      reset_pin_oe_n      <= 1'b1;
      fetch_address       <= RESET_VECTOR;
      execute_hold        <= 1'b1;
      ring_clock_active   <= 1'b0;
      timer_scale_slow    <= 1'b0;
      oscillator_run      <= 1'b1;
      watchdog_on_crystal <= 1'b1;
    end else if (clock_enable) begin
      cpu_reset           <= next_state == reset_state;
      reset_pin_out       <= internal_reset;
      reset_pin_oe_n      <= !internal_reset;
      if (next_state == reset_state) begin
        fetch_address <= RESET_VECTOR;
      end
      execute_hold        <= next_state == reset_state || next_state == warm_state;
      ring_clock_active   <= next_ring;
      timer_scale_slow    <= next_divide == DIVIDE_SLOW && !in_reset;
      // Reset in stop mode restarts the crystal
      oscillator_run      <= !stop_mode || any_reset || in_stop_reset;
      watchdog_on_crystal <= 1'b1;
    end
  end

  chk_exit_within_four: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && state == reset_state && !any_reset && rst_wait == 17'h00000)
    |=> !cpu_reset)
    else $error("reset exit too slow");

  chk_reset_divide: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && in_reset) |=> clock_divide == DIVIDE_RESET)
    else $error("divide not restored on reset");

  chk_slow_refused: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && !switch_back && slow_refused && clock_divide != DIVIDE_SLOW)
    |=> clock_divide != DIVIDE_SLOW)
    else $error("slow write taken while busy");

  chk_switch_back: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && switch_back && !in_reset) |=> clock_divide == DIVIDE_ONE)
    else $error("switchback missed");

  chk_ring_lock: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && (ring_clock_active || next_ring)) |=> clock_divide == DIVIDE_RESET)
    else $error("divide changed on ring clock");

  chk_pin_drive: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && internal_reset) |=> !reset_pin_oe_n && reset_pin_out)
    else $error("reset pin not driven");

  chk_flag_set: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && osc_failed) |=> osc_fail_flag && cpu_reset)
    else $error("failure flag not set");

  chk_stop_no_fail: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && stop_mode && !osc_fail_flag) |=> !osc_fail_hold && !osc_fail_flag)
    else $error("failure reset in stop");

  chk_other_divide: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && !in_reset && !ring_clock_active && !next_ring && !control.write &&
     clock_divide != DIVIDE_SLOW) |=> $stable(clock_divide))
    else $error("divide altered by event");

  chk_warm_running: assert property (@(posedge clock) disable iff (reset)
    (state == warm_state || state == ring_state) |-> warm_busy || warm_done)
    else $error("warmup counter idle during warmup");
endmodule // clock_reset_power_manager
`default_nettype wire

// ==== core/warmup_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module warmup_counter
  import clock_reset_pkg::*;
#(
  parameter int COUNT = WARMUP_CYCLES
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic enable,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  logic [16:0] count;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= 17'h00000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (enable) begin
      done <= 1'b0;
      if (start) begin
        count <= 17'(COUNT - 1);
        busy  <= 1'b1;
      end else if (busy && count == 17'h00000) begin
        busy <= 1'b0;
        done <= 1'b1;
      end else if (busy) begin
        count <= count - 17'h00001;
      end
    end
  end
endmodule // warmup_counter
`default_nettype wire

// ==== include/clock_reset_pkg.sv ====
package clock_reset_pkg;
  localparam logic [1:0]  DIVIDE_QUARTER   = 2'h0;
  localparam logic [1:0]  DIVIDE_RESERVED  = 2'h1;
  localparam logic [1:0]  DIVIDE_ONE       = 2'h2;
  localparam logic [1:0]  DIVIDE_SLOW      = 2'h3;
  localparam logic [1:0]  DIVIDE_RESET     = 2'h2;
  localparam int          PMR_DIVIDE_HI    = 7;
  localparam int          PMR_DIVIDE_LO    = 6;
  localparam int          PMR_RESTORE_BIT  = 5;
  localparam int          POWER_CONTROL_REGISTER_DETECT_BIT  = 4;
  localparam int          POWER_CONTROL_REGISTER_FLAG_BIT    = 5;
  localparam int          EXTENDED_IRQ_FLAG_REGISTER_RING_BIT    = 1;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam int          PIN_MIN_CYCLES   = 3;
  localparam int          EXIT_MAX_CYCLES  = 4;
  localparam int          WARMUP_CYCLES    = 65536;
  localparam int          SLOW_RATIO       = 1024;
  localparam int          CLOCK_PERIOD_NS  = 10;

  typedef struct packed {
    logic [5:0] irq_level;
    logic [5:0] irq_enable;
    logic [5:0] irq_allowed;
    logic [1:0] rx_pin;
    logic [1:0] rx_enable;
    logic [1:0] tx_busy;
    logic [1:0] rx_busy;
  } wake_type;

  typedef struct packed {
    logic       write;
    logic [1:0] divide;
    logic       restore_enable;
    logic       detect_write;
    logic       detect_value;
    logic       flag_clear;
    logic       ring_select;
  } control_type;
endpackage

// ==== sim/clock_reset_power_manager_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module clock_reset_power_manager_tb
  import clock_reset_pkg::*;
;
  localparam int WU = 32;
  logic        clock = 1'h0;
  logic        reset = 1'h1;
  logic        hold_reset, stop_mode, stop_exit, crystal_slow;
  logic [5:0]  irq_active, irq_lvl, irq_en, irq_ok;
  logic [1:0]  rx_start, rx_lvl, rx_en, tx_b, rx_b, divide;
  logic [3:0]  src;
  logic        pin_out, pin_oe_n, pin_level, cpu_reset, hold, restore_en;
  logic        detect_en, flag, ring_active, ring_sel, scale_slow, osc_run, wd_xtal;
  logic        clk_en;
  logic [15:0] fetch;
  control_type ctl;
  wake_type    wake;
  int          errors = 0;
  int          n_compared = 0;

  assign wake = {irq_lvl, irq_en, irq_ok, rx_lvl, rx_en, tx_b, rx_b};
  always #5 clock = ~clock;

  ext_world partner (.hold_reset(hold_reset), .irq_active(irq_active), .rx_start(rx_start),
    .reset_pin_out(pin_out), .reset_pin_oe_n(pin_oe_n), .reset_level(pin_level),
    .irq_level(irq_lvl), .rx_level(rx_lvl));

  clock_reset_power_manager #(.WARMUP(WU)) uut (.clock(clock), .reset(reset),
    .clock_enable(clk_en), .reset_pin_in(pin_level), .reset_pin_out(pin_out),
    .reset_pin_oe_n(pin_oe_n), .power_fail_reset(src[2]), .power_on_reset(src[3]),
    .watchdog_reset(src[1]), .system_reset(src[0]), .stop_mode(stop_mode),
    .stop_exit(stop_exit), .crystal_slow(crystal_slow), .wake(wake), .control(ctl),
    .cpu_reset(cpu_reset), .fetch_address(fetch), .execute_hold(hold),
    .clock_divide(divide), .auto_speed_restore_enable(restore_en),
    .osc_fail_detect_enable(detect_en), .osc_fail_flag(flag),
    .ring_clock_active(ring_active), .ring_start_select(ring_sel),
    .timer_scale_slow(scale_slow), .oscillator_run(osc_run), .watchdog_on_crystal(wd_xtal));

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic pulse_ctl(input control_type c);
    ctl = c;
    cyc(1);
    ctl = '0;
    cyc(1);
  endtask

  task automatic wr(input logic [1:0] d, input logic r, input logic g);
    pulse_ctl('{write:1'h1, divide:d, restore_enable:r, ring_select:g, default:'0});
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic t_pin();
    hold_reset = 1'h1;
    cyc(2);
    hold_reset = 1'h0;
    repeat (8) begin
      cyc(1);
      `CHK(cpu_reset, 1'h0)
    end
    wr(DIVIDE_SLOW, 1'h0, 1'h0);
    hold_reset = 1'h1;
    cyc(8);
    `CHK(cpu_reset, 1'h1)
    `CHK(pin_oe_n, 1'h1)
    `CHK(divide, DIVIDE_RESET)
    hold_reset = 1'h0;
    cyc(4);
    `CHK(cpu_reset, 1'h0)
    `CHK(fetch, RESET_VECTOR)
    $display("test pin_reset done");
  endtask

  task automatic t_freeze();
    clk_en = 1'h0;
    wr(DIVIDE_QUARTER, 1'h1, 1'h0);
    `CHK(divide, DIVIDE_RESET)
    `CHK(restore_en, 1'h0)
    clk_en = 1'h1;
    cyc(1);
    `CHK(divide, DIVIDE_RESET)
    $display("test clock_freeze done");
  endtask

  task automatic t_serial();
    wr(DIVIDE_SLOW, 1'h1, 1'h0);
    `CHK(divide, DIVIDE_SLOW)
    `CHK(scale_slow, 1'h1)
    `CHK(restore_en, 1'h1)
    rx_en = 2'h1;
    rx_start = 2'h2;
    cyc(5);
    `CHK(divide, DIVIDE_SLOW)
    rx_start = 2'h3;
    cyc(5);
    `CHK(divide, DIVIDE_ONE)
    `CHK(scale_slow, 1'h0)
    rx_start = 2'h0;
    wr(DIVIDE_SLOW, 1'h1, 1'h0);
    tx_b = 2'h2;
    cyc(4);
    `CHK(divide, DIVIDE_ONE)
    wr(DIVIDE_SLOW, 1'h1, 1'h0);
    `CHK(divide, DIVIDE_ONE)
    tx_b = 2'h0;
    wr(DIVIDE_SLOW, 1'h0, 1'h0);
    rx_en = 2'h3;
    rx_start = 2'h3;
    cyc(5);
    `CHK(divide, DIVIDE_SLOW)
    rx_start = 2'h0;
    wr(DIVIDE_QUARTER, 1'h1, 1'h0);
    rx_start = 2'h1;
    cyc(5);
    `CHK(divide, DIVIDE_QUARTER)
    rx_start = 2'h0;
    rx_en = 2'h0;
    $display("test serial_switchback done");
  endtask

  task automatic t_irq();
    for (int i = 0; i < 6; i++) begin
      wr(DIVIDE_SLOW, 1'h1, 1'h0);
      irq_en = 6'h01 << i;
      irq_active = 6'h01 << i;
      cyc(5);
      `CHK(divide, DIVIDE_SLOW)
      irq_active = 6'h00;
      cyc(3);
      irq_ok = 6'h01 << i;
      cyc(5);
      `CHK(divide, DIVIDE_SLOW)
      irq_active = 6'h01 << i;
      cyc(5);
      `CHK(divide, DIVIDE_ONE)
      irq_active = 6'h00;
      irq_ok = 6'h00;
      cyc(2);
    end
    irq_en = 6'h00;
    $display("test irq_switchback done");
  endtask

  task automatic t_internal();
    for (int i = 0; i < 3; i++) begin
      wr(DIVIDE_SLOW, 1'h0, 1'h0);
      src = 4'h1 << i;
      cyc(4);
      `CHK(cpu_reset, 1'h1)
      `CHK(pin_oe_n, 1'h0)
      `CHK(pin_level, 1'h1)
      `CHK(divide, DIVIDE_RESET)
      src = 4'h0;
      cyc(14);
      `CHK(pin_oe_n, 1'h1)
      `CHK(cpu_reset, 1'h0)
    end
    $display("test internal_reset done");
  endtask

  task automatic t_oscfail();
    pulse_ctl('{detect_write:1'h1, detect_value:1'h1, default:'0});
    `CHK(detect_en, 1'h1)
    stop_mode = 1'h1;
    crystal_slow = 1'h1;
    cyc(8);
    `CHK(cpu_reset, 1'h0)
    stop_mode = 1'h0;
    cyc(8);
    `CHK(cpu_reset, 1'h1)
    `CHK(flag, 1'h1)
    crystal_slow = 1'h0;
    cyc(12);
    `CHK(cpu_reset, 1'h0)
    `CHK(detect_en, 1'h1)
    pulse_ctl('{flag_clear:1'h1, default:'0});
    `CHK(flag, 1'h0)
    src = 4'h8;
    cyc(3);
    src = 4'h0;
    cyc(12);
    `CHK(detect_en, 1'h1)
    src = 4'h4;
    cyc(3);
    src = 4'h0;
    cyc(14);
    `CHK(detect_en, 1'h0)
    $display("test osc_fail done");
  endtask

  task automatic t_stop();
    stop_mode = 1'h1;
    cyc(2);
    `CHK(osc_run, 1'h0)
    hold_reset = 1'h1;
    cyc(8);
    `CHK(osc_run, 1'h1)
    stop_mode = 1'h0;
    hold_reset = 1'h0;
    cyc(12);
    `CHK(cpu_reset | hold, 1'h1)
    cyc(WU + 8);
    `CHK(cpu_reset | hold, 1'h0)
    `CHK(osc_run, 1'h1)
    for (int g = 1; g >= 0; g--) begin
      wr(DIVIDE_ONE, 1'h0, g[0]);
      stop_mode = 1'h1;
      cyc(4);
      stop_mode = 1'h0;
      stop_exit = 1'h1;
      cyc(1);
      stop_exit = 1'h0;
      cyc(2);
      `CHK(ring_active, g[0])
      `CHK(hold, ~g[0])
      `CHK(wd_xtal, 1'h1)
      wr(DIVIDE_SLOW, 1'h0, g[0]);
      `CHK(divide, g[0] ? DIVIDE_ONE : DIVIDE_SLOW)
      cyc(WU + 8);
      `CHK(ring_active | hold, 1'h0)
    end
    $display("test stop_exit done");
  endtask

  initial begin
    {hold_reset, stop_mode, stop_exit, crystal_slow} = 4'h0;
    {irq_active, irq_en, irq_ok} = 18'h0;
    {rx_start, rx_en, tx_b, rx_b, src} = 12'h0;
    ctl = '0;
    clk_en = 1'h1;
    cyc(6);
    reset = 1'h0;
    cyc(3);
    t_pin();
    t_freeze();
    t_serial();
    t_irq();
    t_internal();
    t_oscfail();
    t_stop();
    close_out();
  end

  // Whole run is about 500 cycles; this leaves wide margin
  initial begin
    #200000;
    errors++;
    close_out();
  end
endmodule // clock_reset_power_manager_tb
`default_nettype wire

// ==== sim/ext_world.sv ====
`timescale 1ns/1ps
`default_nettype none
module ext_world (
  input  wire logic       hold_reset,
  input  wire logic [5:0] irq_active,
  input  wire logic [1:0] rx_start,
  input  wire logic       reset_pin_out,
  input  wire logic       reset_pin_oe_n,
  output logic            reset_level,
  output logic [5:0]      irq_level,
  output logic [1:0]      rx_level
);
  // Pin has a pull-down, so it reads low when nobody drives it
  assign reset_level = hold_reset | (~reset_pin_oe_n & reset_pin_out);
  // Pins a, b, d and f are active low; c and e active high
  assign irq_level = irq_active ^ 6'h2B;
  // Receive lines idle high; a start bit pulls them low
  assign rx_level = ~rx_start;
endmodule // ext_world
`default_nettype wire
